// file: design/sadma_regs.vh
// Register map, field positions and constants for the short-address DMA
// How it works
// R01 - Each channel picks idle or repeat mode alone, independent of others.
// R02 - Idle mode moves one byte or word per request until count done.
// R03 - Serial port 0 receive-full copies I/O to memory; others memory to I/O.
// R04 - Memory address is 24 bits; I/O address low 8 bits, upper 16 ones.
// R05 - Idle mode holds both addresses fixed across transfers.
// R06 - Idle count drops per transfer; at zero clear enable, stop, interrupt.
// R07 - Idle count loaded with zero means 65,536 transfers.
// R08 - Sources: timer 0-3 events, serial port 0 empty/full, external request.
// R09 - Repeat mode restores address and count at cycle end and continues.
// R10 - Repeat: upper byte runs down, reloads from lower byte at zero.
// R11 - Repeat address steps by size; reload subtracts step times initial count.
// R12 - Software loads both count bytes equal before enabling repeat mode.
// R13 - Repeat runs until enable cleared; re-enable resumes from held state.
// R14 - Repeat mode never raises an interrupt.
// R15 - Repeat counts are 8 bits; largest cycle is 255 transfers.
// R16 - Repeat mode keeps the I/O address constant.
// R17 - Size 0 byte, 1 word; direction 0 increment, 1 decrement.
// R18 - Each transfer reads source then writes destination before next request.
`ifndef SADMA_REGS_VH
`define SADMA_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SADMA_OFF_MEM_ADDR  8'h00
`define SADMA_OFF_IO_ADDR   8'h04
`define SADMA_OFF_COUNT     8'h08
`define SADMA_OFF_CONTROL   8'h0C
`define SADMA_OFF_STATUS    8'h10
`define SADMA_OFF_MASK      8'h14
`define SADMA_OFF_STATE     8'h18

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SADMA_CTL_ENABLE    0
`define SADMA_CTL_REPEAT    1
`define SADMA_CTL_SIZE      2
`define SADMA_CTL_DIR       3
`define SADMA_CTL_SRC_LO    4
`define SADMA_CTL_SRC_HI    6
`define SADMA_SRC_RXFULL    3'h5
`define SADMA_NUM_SRC       7

// ----------------------------------------
// Fixed values
// ----------------------------------------
`define SADMA_IO_UPPER      16'hFFFF
`define SADMA_RESP_OKAY     2'h0
`define SADMA_RESP_SLVERR   2'h2

`endif

// file: design/sadma_trig.v
// Request synchroniser and edge detector for the activation sources
module sadma_trig (
	input  wire       clock,
	input  wire       rst,
	input  wire [6:0] req_in,
	output wire [6:0] req_pulse
);

reg [6:0] sync1;
reg [6:0] sync2;
reg [6:0] prev;

// ----------------------------------------
// Two-stage sync then rising-edge pulse
// ----------------------------------------
genvar i;
generate
	for (i = 0; i < 7; i = i + 1) begin : g_src
		always @(posedge clock or posedge rst) begin
			if (rst) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
				prev[i]  <= 1'b0;
			end else begin
				sync1[i] <= req_in[i];
				sync2[i] <= sync1[i];
				prev[i]  <= sync2[i];
			end
		end
		assign req_pulse[i] = sync2[i] & ~prev[i]; // [R08]
	end
endgenerate

endmodule // sadma_trig

// file: design/sadma_chan.v
// Short-address DMA channel, idle and repeat modes, AXI4-Lite registers
`include "sadma_regs.vh"
module sadma_chan (
	input  wire        clock,
	input  wire        rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [6:0]  req_in,
	output reg         bus_req,
	output reg         bus_write,
	output reg  [23:0] bus_addr,
	output reg         bus_word,
	output reg  [15:0] bus_wdata,
	input  wire [15:0] bus_rdata,
	input  wire        bus_ack,
	output wire        irq
);

// ----------------------------------------
// State and registers
// ----------------------------------------
localparam ST_IDLE  = 3'b001;
localparam ST_READ  = 3'b010;
localparam ST_WRITE = 3'b100;

reg [2:0]  state;
reg [23:0] mem_addr;
reg [7:0]  io_addr;
reg [15:0] count;
reg        enable;
reg        repeat_mode;
reg        size_sel;
reg        dir_sel;
reg [2:0]  src_sel;
reg        to_mem;
reg        status_done;
reg        mask_done;
reg [7:0]  aw_addr;
reg        aw_held;
reg [31:0] w_data;
reg [3:0]  w_strb;
reg        w_held;
reg        irq_level;

wire [6:0]  req_pulse;
wire [23:0] io_full = {`SADMA_IO_UPPER, io_addr}; // [R04]
wire        hit;
wire        go;
wire        wr_fire;
wire        done_evt;
wire        xfer_end;
wire [7:0]  run_byte  = count[15:8];
wire [7:0]  init_byte = count[7:0];
wire [23:0] step;
wire [23:0] span;
wire [15:0] next_count;
wire [23:0] next_mem_addr;

sadma_trig u_trig (
	.clock     (clock),
	.rst       (rst),
	.req_in    (req_in),
	.req_pulse (req_pulse)
);

function [6:0] src_onehot;
	input [2:0] sel;
	begin
		src_onehot = 7'h00;
		if (sel < 3'h7)
			src_onehot[sel] = 1'b1;
	end
endfunction

// ----------------------------------------
// Decoders shared by several paths
// ----------------------------------------
// Running byte at one ends the cycle; zero is taken the same way
function cycle_end;
	input [7:0] run;
	begin
		cycle_end = (run == 8'h01) || (run == 8'h00);
	end
endfunction

function is_rx_src;
	input [2:0] sel;
	begin
		is_rx_src = (sel == `SADMA_SRC_RXFULL);
	end
endfunction

// Unmapped offsets answer with an error and change nothing
function addr_known;
	input [7:0] a;
	begin
		case (a)
		`SADMA_OFF_MEM_ADDR, `SADMA_OFF_IO_ADDR, `SADMA_OFF_COUNT,
		`SADMA_OFF_CONTROL, `SADMA_OFF_STATUS, `SADMA_OFF_MASK,
		`SADMA_OFF_STATE:
			addr_known = 1'b1;
		default:
			addr_known = 1'b0;
		endcase
	end
endfunction

// Selected source only: channel config never touches any other channel
assign hit = |(req_pulse & src_onehot(src_sel)); // [R01] [R08]
assign go  = enable && (state == ST_IDLE) && hit;

// ----------------------------------------
// Count and address arithmetic
// ----------------------------------------
// Byte step 1, word step 2
assign step = size_sel ? 24'h000002 : 24'h000001; // [R17]
assign span = size_sel ? {15'h0000, init_byte, 1'b0}
		: {16'h0000, init_byte}; // [R11]

// Idle wraps 0 to FFFF so zero gives 65,536 transfers
assign next_count = repeat_mode ?
	(cycle_end(run_byte) ? {init_byte, init_byte}
		: {run_byte - 8'h01, init_byte}) // [R10] [R15]
	: count - 16'h0001; // [R06] [R07]

// Reload subtracts signed step times initial count from walked address
assign next_mem_addr = !repeat_mode ? mem_addr : // [R05]
	(cycle_end(run_byte) ?
		(dir_sel ? mem_addr - step + span : mem_addr + step - span)
		: (dir_sel ? mem_addr - step : mem_addr + step)); // [R09] [R11]

assign xfer_end = (state == ST_WRITE) && bus_ack; // [R18]
assign done_evt = xfer_end && !repeat_mode
	&& count == 16'h0001; // [R06] [R14]

// ----------------------------------------
// Transfer engine
// ----------------------------------------
always @(posedge clock or posedge rst) begin
	if (rst) begin
		state     <= ST_IDLE;
		bus_req   <= 1'b0;
		bus_write <= 1'b0;
		bus_addr  <= 24'h000000;
		bus_word  <= 1'b0;
		bus_wdata <= 16'h0000;
		to_mem    <= 1'b0;
	end else begin
		case (state)
		ST_IDLE: begin
			if (go) begin
				// Direction latched per request from its source
				to_mem    <= is_rx_src(src_sel); // [R03]
				bus_req   <= 1'b1;
				bus_write <= 1'b0;
				bus_word  <= size_sel; // [R02]
				bus_addr  <= is_rx_src(src_sel)
					? io_full : mem_addr; // [R03] [R18]
				state     <= ST_READ;
			end
		end
		ST_READ: begin
			if (bus_ack) begin
				bus_wdata <= bus_rdata;
				bus_write <= 1'b1;
				bus_addr  <= to_mem ? mem_addr : io_full; // [R18]
				state     <= ST_WRITE;
			end
		end
		ST_WRITE: begin
			if (bus_ack) begin
				bus_req   <= 1'b0;
				bus_write <= 1'b0;
				state     <= ST_IDLE; // [R18]
			end
		end
		default: begin
			state   <= ST_IDLE;
			bus_req <= 1'b0;
		end
		endcase
	end
end

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready  = !w_held && !s_axi_bvalid;
assign wr_fire = aw_held && w_held && !s_axi_bvalid;

always @(posedge clock or posedge rst) begin
	if (rst) begin
		aw_held <= 1'b0;
		w_held  <= 1'b0;
		aw_addr <= 8'h00;
		w_data  <= 32'h00000000;
		w_strb  <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= `SADMA_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_known(aw_addr) ? `SADMA_RESP_OKAY
				: `SADMA_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------
// Register file and channel state update
// ----------------------------------------
always @(posedge clock or posedge rst) begin
	if (rst) begin
		mem_addr    <= 24'h000000;
		io_addr     <= 8'h00;
		count       <= 16'h0000;
		enable      <= 1'b0;
		repeat_mode <= 1'b0;
		size_sel    <= 1'b0;
		dir_sel     <= 1'b0;
		src_sel     <= 3'h0;
		status_done <= 1'b0;
		mask_done   <= 1'b0;
	end else begin
		if (wr_fire) begin
			case (aw_addr)
			`SADMA_OFF_MEM_ADDR: begin
				if (w_strb[0]) mem_addr[7:0]   <= w_data[7:0];
				if (w_strb[1]) mem_addr[15:8]  <= w_data[15:8];
				if (w_strb[2]) mem_addr[23:16] <= w_data[23:16];
			end
			`SADMA_OFF_IO_ADDR:
				if (w_strb[0]) io_addr <= w_data[7:0]; // [R04]
			`SADMA_OFF_COUNT: begin
				if (w_strb[0]) count[7:0]  <= w_data[7:0]; // [R12]
				if (w_strb[1]) count[15:8] <= w_data[15:8];
			end
			`SADMA_OFF_CONTROL:
				if (w_strb[0]) begin
					// Clearing leaves address and count: resume point
					enable      <= w_data[`SADMA_CTL_ENABLE]; // [R13]
					repeat_mode <= w_data[`SADMA_CTL_REPEAT]; // [R01]
					size_sel    <= w_data[`SADMA_CTL_SIZE]; // [R17]
					dir_sel     <= w_data[`SADMA_CTL_DIR]; // [R17]
					src_sel     <= w_data[`SADMA_CTL_SRC_HI:`SADMA_CTL_SRC_LO];
				end
			`SADMA_OFF_MASK:
				if (w_strb[0]) mask_done <= w_data[0];
			default: begin
			end
			endcase
		end
		// Write-one clear; a completion in the same cycle wins
		if (wr_fire && aw_addr == `SADMA_OFF_STATUS && w_strb[0]
				&& w_data[0])
			status_done <= 1'b0;
		if (done_evt)
			status_done <= 1'b1; // [R06]
		// Engine update after the write so completion overrides software
		if (xfer_end) begin
			count    <= next_count; // [R02] [R10]
			mem_addr <= next_mem_addr; // [R05] [R09] [R16]
			if (done_evt)
				enable <= 1'b0; // [R06]
		end
	end
end

// ----------------------------------------
// Interrupt output
// ----------------------------------------
// Registered so the pin never carries a decode glitch
always @(posedge clock or posedge rst) begin
	if (rst) begin
		irq_level <= 1'b0;
	end else begin
		irq_level <= status_done & mask_done; // [R06] [R14]
	end
end

assign irq = irq_level;

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
assign s_axi_arready = !s_axi_rvalid;

always @(posedge clock or posedge rst) begin
	if (rst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h00000000;
		s_axi_rresp  <= `SADMA_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp  <= addr_known(s_axi_araddr) ? `SADMA_RESP_OKAY
			: `SADMA_RESP_SLVERR;
		case (s_axi_araddr)
		`SADMA_OFF_MEM_ADDR: s_axi_rdata <= {8'h00, mem_addr};
		`SADMA_OFF_IO_ADDR:  s_axi_rdata <= {24'h000000, io_addr};
		`SADMA_OFF_COUNT:    s_axi_rdata <= {16'h0000, count};
		`SADMA_OFF_CONTROL:
			s_axi_rdata <= {25'h0000000, src_sel, dir_sel, size_sel,
				repeat_mode, enable};
		`SADMA_OFF_STATUS:   s_axi_rdata <= {31'h00000000, status_done};
		`SADMA_OFF_MASK:     s_axi_rdata <= {31'h00000000, mask_done};
		`SADMA_OFF_STATE:    s_axi_rdata <= {29'h00000000, state};
		default: begin
			s_axi_rdata <= 32'h00000000;
		end
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule // sadma_chan

// file: verification/sadma_mem.sv
// Bus partner model: memory and I/O space answering the channel
module sadma_mem (
	input  wire        clock,
	input  wire        rst,
	input  wire        slow,
	input  wire        bus_req,
	input  wire        bus_write,
	input  wire [23:0] bus_addr,
	output reg  [15:0] bus_rdata,
	output reg         bus_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	reg tog;
	// Lines toggle outside reads so a stale sample cannot pass
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tog       <= 1'b0;
			bus_ack   <= 1'b0;
			bus_rdata <= 16'h0000;
		end else begin
			tog       <= ~tog;
			bus_ack   <= bus_req && !bus_ack && (!slow || tog);
			bus_rdata <= (bus_req && !bus_write) ?
				bus_addr[15:0] ^ 16'h5A3C : ~bus_rdata;
		end
	end
endmodule // sadma_mem

// file: verification/sadma_chk.sv
// Checker for the DMA bus and register handshakes of the channel
module sadma_chk (
	input wire        clock,
	input wire        rst,
	input wire        bus_req,
	input wire        bus_write,
	input wire        bus_ack,
	input wire [23:0] bus_addr,
	input wire [15:0] bus_wdata,
	input wire [15:0] bus_rdata,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_awready,
	input wire        s_axi_arvalid,
	input wire        s_axi_rvalid,
	input wire        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	wire rd_done = bus_req && !bus_write && bus_ack;
	wire wr_done = bus_req && bus_write && bus_ack;
	phase_step_a:
		assert property (rd_done |=> bus_req && bus_write)
		else $error("read phase did not turn to write");
	data_pass_a:
		assert property (rd_done |=> bus_wdata == $past(bus_rdata))
		else $error("write data differs from read data");
	io_side_a:
		assert property (rd_done |=> bus_addr[23:8] == 16'hFFFF
			|| $past(bus_addr[23:8]) == 16'hFFFF)
		else $error("neither side used the I/O page");
	xfer_end_a:
		assert property (wr_done |=> !bus_req)
		else $error("bus request held after write");
	req_hold_a:
		assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
		else $error("bus request changed before ack");
	resp_hold_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	aw_block_a:
		assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	rd_answer_a:
		assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read answer late");
	cover property (rd_done);
	cover property ($rose(irq));
	cover property (s_axi_bvalid && !s_axi_bready);
endmodule // sadma_chk
bind sadma_chan sadma_chk u_chk (.clock(clock), .rst(rst), .bus_req(bus_req),
	.bus_write(bus_write), .bus_ack(bus_ack), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .irq(irq),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_awready(s_axi_awready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_rvalid(s_axi_rvalid));

// file: verification/test_short_addr_dma_idle_repeat.sv
// Self-checking bench for the short-address DMA channel
`include "sadma_regs.vh"
module test_short_addr_dma_idle_repeat;
	timeunit 1ns;
	timeprecision 1ps;
	reg         clock, rst, awv, wv, bry, arv, rry, slow;
	reg  [7:0]  awa, ara;
	reg  [31:0] wd, ma;
	reg  [6:0]  req;
	reg  [40:0] q[$];
	wire        awr, wrd, bv, arr, rv, breq, bw, bword, ack, irq;
	wire [1:0]  br, rr;
	wire [31:0] rdat;
	wire [23:0] badr;
	wire [15:0] bwd, brd;
	integer     n_mismatch, n_checks, cyc, i, seed, rnd;
	sadma_chan uut (.clock(clock), .rst(rst), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .req_in(req), .bus_req(breq), .bus_write(bw),
		.bus_addr(badr), .bus_word(bword), .bus_wdata(bwd),
		.bus_rdata(brd), .bus_ack(ack), .irq(irq));
	sadma_mem far (.clock(clock), .rst(rst), .slow(slow), .bus_req(breq),
		.bus_write(bw), .bus_addr(badr), .bus_rdata(brd), .bus_ack(ack));
	function [15:0] f(input [31:0] a);
		f = a[15:0] ^ 16'h5A3C;
	endfunction
	task chk(input string nm, input [40:0] s, input [40:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] e);
		begin
			@(posedge clock);
			{awa, wd, awv, wv} <= {a, d, 2'b11};
			@(posedge clock);
			while (awv || wv) begin
				if (awr) awv <= 1'b0;
				if (wrd) wv <= 1'b0;
				@(posedge clock);
			end
			// Late bready so the response must stand
			@(posedge clock);
			bry <= 1'b1;
			@(posedge clock);
			while (bv !== 1'b1) @(posedge clock);
			chk("bresp", br, e);
			bry <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] d, input [1:0] e);
		begin
			@(posedge clock);
			{ara, arv, rry} <= {a, 2'b11};
			@(posedge clock);
			while (arr !== 1'b1) @(posedge clock);
			arv <= 1'b0;
			@(posedge clock);
			while (rv !== 1'b1) @(posedge clock);
			chk("rdata", rdat, d);
			chk("rresp", rr, e);
			rry <= 1'b0;
		end
	endtask
	task trig(input integer n, input integer ok, input [40:0] e);
		begin
			if (ok) q.push_back(e);
			@(posedge clock);
			req[n] <= 1'b1;
			rnd = $random(seed);
			slow <= rnd[0];
			repeat (20) @(posedge clock);
			req[n] <= 1'b0;
			repeat (5) @(posedge clock);
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_mismatch);
			if (n_mismatch == 0 && n_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	always @(posedge clock)
		if (!rst && breq && bw && ack) begin
			if (q.size() == 0)
				chk("spare", 41'h1, 41'h0);
			else
				chk("xfer", {bword, badr, bwd}, q.pop_front());
		end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop;
		end
	end
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		rst = 1'b1;
		{awv, wv, bry, arv, rry, slow, req, awa, ara, wd} = 0;
		{n_mismatch, n_checks, cyc} = 0;
		seed = 32'h474FB8E1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		ma = ($random(seed) & 32'h7FFFFE) | 32'h10;
		// ---------------------------------------------
		// Idle mode, word, memory to I/O, timer source
		// ---------------------------------------------
		wr(`SADMA_OFF_MASK, 1, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_MEM_ADDR, ma, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_IO_ADDR, 32'h34, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_COUNT, 3, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_CONTROL, 32'h05, `SADMA_RESP_OKAY);
		trig(6, 0, 0);
		for (i = 0; i < 3; i = i + 1)
			trig(0, 1, {1'b1, 24'hFFFF34, f(ma)});
		trig(0, 0, 0);
		rd(`SADMA_OFF_CONTROL, 32'h04, `SADMA_RESP_OKAY);
		rd(`SADMA_OFF_COUNT, 0, `SADMA_RESP_OKAY);
		rd(`SADMA_OFF_MEM_ADDR, ma & 32'hFFFFFF, `SADMA_RESP_OKAY);
		chk("irq", irq, 1);
		wr(`SADMA_OFF_MASK, 0, `SADMA_RESP_OKAY);
		chk("irq", irq, 0);
		wr(`SADMA_OFF_MASK, 1, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_STATUS, 1, `SADMA_RESP_OKAY);
		chk("irq", irq, 0);
		// ---------------------------------------------
		// Idle mode, receive source, count zero is max
		// ---------------------------------------------
		wr(`SADMA_OFF_COUNT, 0, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_CONTROL, 32'h51, `SADMA_RESP_OKAY);
		trig(5, 1, {1'b0, ma[23:0], f(32'hFFFF34)});
		rd(`SADMA_OFF_COUNT, 32'hFFFF, `SADMA_RESP_OKAY);
		rd(`SADMA_OFF_CONTROL, 32'h51, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_CONTROL, 32'h50, `SADMA_RESP_OKAY);
		// ---------------------------------------------
		// Repeat mode, byte, decrement, external source
		// ---------------------------------------------
		wr(`SADMA_OFF_COUNT, 32'h0202, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_CONTROL, 32'h6B, `SADMA_RESP_OKAY);
		for (i = 0; i < 5; i = i + 1)
			trig(6, 1, {1'b0, 24'hFFFF34, f(ma - i % 2)});
		wr(`SADMA_OFF_CONTROL, 32'h6A, `SADMA_RESP_OKAY);
		trig(6, 0, 0);
		rd(`SADMA_OFF_MEM_ADDR, (ma - 1) & 32'hFFFFFF, `SADMA_RESP_OKAY);
		rd(`SADMA_OFF_COUNT, 32'h0102, `SADMA_RESP_OKAY);
		wr(`SADMA_OFF_CONTROL, 32'h6B, `SADMA_RESP_OKAY);
		trig(6, 1, {1'b0, 24'hFFFF34, f(ma - 1)});
		trig(6, 1, {1'b0, 24'hFFFF34, f(ma)});
		rd(`SADMA_OFF_STATUS, 0, `SADMA_RESP_OKAY);
		chk("irq", irq, 0);
		// Unmapped place answers with an error
		rd(8'h1C, 0, `SADMA_RESP_SLVERR);
		wr(8'h1C, 32'hFF, `SADMA_RESP_SLVERR);
		repeat (4) @(posedge clock);
		chk("queue", q.size(), 0);
		report_and_stop;
	end
endmodule // test_short_addr_dma_idle_repeat
